// ---- logic/bpi_pkg.sv ----
// Operation
// - ignition overcurrent steps inverter frequency upward
// - second-level inverter overcurrent latches full shutdown
// - gates held low during supply lockout
// - dead interval between inverter gate edges
// - enable at turn-on level, lockout below
// - startup boost: fixed off-time, rising on-time
// - valid zero-current switches boost to variable frequency
// - boost overcurrent ends pulse, waits zero-current
// - missing zero-current restarts boost after timeout
// - zero-current falling edge starts next pulse
// - bus open-loop, undervoltage and overvoltage flagged
// - preheat time quantized into setting steps
// - latched fault holds until lamp removal or supply lockout
package bpi_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned NS_PER_MS = 1_000_000;
  localparam int unsigned INV_L1_QUAL_NS = 250;
  localparam int unsigned INV_L1_QUAL_CYC = (INV_L1_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INV_L2_QUAL_NS = 400;
  localparam int unsigned INV_L2_QUAL_CYC = (INV_L2_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BOOST_CUR_QUAL_NS = 260;
  localparam int unsigned BOOST_CUR_QUAL_CYC =
    (BOOST_CUR_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEAD_NS = 1800;
  localparam int unsigned DEAD_CYC = DEAD_NS / CLK_PERIOD_NS;
  localparam int unsigned BOOST_TON_MIN_NS = 1000;
  localparam int unsigned BOOST_TON_MIN_CYC = BOOST_TON_MIN_NS / CLK_PERIOD_NS;
  localparam int unsigned BOOST_TON_STEP_NS = 1000;
  localparam int unsigned BOOST_TON_STEP_CYC = BOOST_TON_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned BOOST_TON_MAX_NS = 24000;
  localparam int unsigned BOOST_TON_MAX_CYC = BOOST_TON_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned BOOST_TOFF_NS = 40000;
  localparam int unsigned BOOST_TOFF_CYC = BOOST_TOFF_NS / CLK_PERIOD_NS;
  localparam int unsigned ZCD_TO_NS = 40000;
  localparam int unsigned ZCD_TO_CYC = ZCD_TO_NS / CLK_PERIOD_NS;
  localparam int unsigned PH_MAX_MS = 2000;
  localparam int unsigned PH_STEPS = 127;
  localparam int unsigned PH_STEP_CYC =
    32'((64'(PH_MAX_MS) * 64'(NS_PER_MS)) / 64'(PH_STEPS * CLK_PERIOD_NS));
  localparam int unsigned IGN_MS = 40;
  localparam int unsigned IGN_CYC = (IGN_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int unsigned IGN_HALF_STEP_NS = 200;
  localparam int unsigned IGN_HALF_STEP_CYC = IGN_HALF_STEP_NS / CLK_PERIOD_NS;
  localparam logic [1:0] IGN_MAX_STEPS = 2'h3;

  // ---------------------------------------------------------------
  // comparator inputs, bit 9 first
  // ---------------------------------------------------------------
  localparam int unsigned SENSE_W = 10;
  typedef struct packed {
    logic lamp_removal;
    logic bus_voltage_sense_over;
    logic bus_voltage_sense_under;
    logic bus_voltage_sense_open;
    logic supply_lockout;
    logic supply_on;
    logic boost_zero_current_in;
    logic boost_current_sense;
    logic inv_low_current_sense_2;
    logic inv_low_current_sense_1;
  } bpi_sense_t;
  localparam int unsigned QUAL_TAB [SENSE_W] = '{INV_L1_QUAL_CYC, INV_L2_QUAL_CYC,
    BOOST_CUR_QUAL_CYC, 1, 1, 1, 1, 1, 1, 1};

  // ---------------------------------------------------------------
  // operating modes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {M_LOCKOUT, M_BUS_CHECK, M_PREHEAT, M_IGNITION, M_RUN, M_FAULT} bpi_mode_t;
  typedef enum logic {B_OFF, B_ON} bpi_boost_ph_t;

endpackage

// ---- logic/bpi_qualifier.sv ----
`timescale 1ns/100ps
`default_nettype none
module bpi_qualifier #(
  parameter int unsigned QUAL_CYC = 1,
  parameter int unsigned CNT_W = 8
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // comparator level in, qualified level out
  input wire logic i_level,
  output logic o_level
);
  import bpi_pkg::*;

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic [CNT_W-1:0] cnt;
    logic q;
  } bpi_qual_st_t;
  localparam bpi_qual_st_t QU_RST = '{ff1: 1'b0, ff2: 1'b0, cnt: '0, q: 1'b0};

  bpi_qual_st_t st_q;
  bpi_qual_st_t st_d;

  // two-stage sync, then count consecutive high cycles
  always_comb begin
    st_d = st_q;
    st_d.ff1 = i_level;
    st_d.ff2 = st_q.ff1;
    st_d.cnt = '0;
    st_d.q = 1'b0;
    if (st_q.ff2) begin
      st_d.cnt = (&st_q.cnt) ? st_q.cnt : st_q.cnt + 1'b1;
      st_d.q = (32'(st_q.cnt) + 32'h0000_0001) >= QUAL_CYC;
    end
  end

  // state register
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      st_q <= QU_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_level = st_q.q;

  property p_qual;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    st_q.q |-> (32'(st_q.cnt) >= QUAL_CYC) && $past(st_q.ff2);
  endproperty
  a_qual: assert property (p_qual)
    else $error("qualified level without enough high cycles");

endmodule // bpi_qualifier
`default_nettype wire

// ---- logic/bpi_inv_bridge.sv ----
`timescale 1ns/100ps
`default_nettype none
module bpi_inv_bridge #(
  parameter int unsigned HALF_W = 16,
  parameter int unsigned DEAD_CYC = bpi_pkg::DEAD_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // run request and half period in cycles
  input wire logic i_run,
  input wire logic [HALF_W-1:0] i_half_cyc,
  // gate drives
  output logic o_inv_low_gate,
  output logic o_inv_high_gate
);
  import bpi_pkg::*;

  typedef enum logic [2:0] {I_IDLE, I_LOW, I_DEAD_H, I_HIGH, I_DEAD_L} bpi_br_ph_t;
  typedef struct packed {
    bpi_br_ph_t ph;
    logic [15:0] cnt;
    logic [15:0] gap;
    logic low;
    logic high;
  } bpi_br_st_t;
  localparam bpi_br_st_t BR_RST =
    '{ph: I_IDLE, cnt: 16'h0000, gap: 16'h0000, low: 1'b0, high: 1'b0};

  bpi_br_st_t st_q;
  bpi_br_st_t st_d;
  logic half_done;
  logic dead_done;

  // half-bridge sequence, low side first after a start
  always_comb begin
    st_d = st_q;
    half_done = (32'(st_q.cnt) + 32'h0000_0001) >= 32'(i_half_cyc);
    dead_done = (32'(st_q.cnt) + 32'h0000_0001) >= DEAD_CYC;
    st_d.cnt = st_q.cnt + 16'h0001;
    case (st_q.ph)
      I_IDLE: begin
        st_d.cnt = 16'h0000;
        if (i_run) begin
          st_d.ph = I_LOW;
        end
      end
      I_LOW: begin
        if (half_done) begin
          st_d.ph = I_DEAD_H;
          st_d.cnt = 16'h0000;
        end
      end
      I_DEAD_H: begin
        if (dead_done) begin
          st_d.ph = I_HIGH;
          st_d.cnt = 16'h0000;
        end
      end
      I_HIGH: begin
        if (half_done) begin
          st_d.ph = I_DEAD_L;
          st_d.cnt = 16'h0000;
        end
      end
      I_DEAD_L: begin
        if (dead_done) begin
          st_d.ph = I_LOW;
          st_d.cnt = 16'h0000;
        end
      end
      default: begin
        st_d.ph = I_IDLE;
      end
    endcase
    if (!i_run) begin
      st_d.ph = I_IDLE;
      st_d.cnt = 16'h0000;
    end
    st_d.low = (st_d.ph == I_LOW);
    st_d.high = (st_d.ph == I_HIGH);
    st_d.gap = (st_d.low || st_d.high) ? 16'h0000 : ((&st_q.gap) ? st_q.gap : st_q.gap + 16'h0001);
  end

  // state register
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      st_q <= BR_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_inv_low_gate = st_q.low;
  assign o_inv_high_gate = st_q.high;

  property p_no_overlap;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    !(st_q.low && st_q.high);
  endproperty
  a_no_overlap: assert property (p_no_overlap)
    else $error("both inverter gates high");

  property p_dead;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    ($rose(st_q.high) || (st_q.low && !$past(st_q.low) && $past(st_q.ph) == I_DEAD_L))
      |-> 32'($past(st_q.gap)) >= DEAD_CYC;
  endproperty
  a_dead: assert property (p_dead)
    else $error("dead interval too short");

endmodule // bpi_inv_bridge
`default_nettype wire

// ---- logic/bpi_ballast_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none
module bpi_ballast_ctrl #(
  parameter int unsigned PH_SET_W = 7,
  parameter int unsigned TON_MAX_CYC = bpi_pkg::BOOST_TON_MAX_CYC,
  parameter int unsigned TOFF_CYC = bpi_pkg::BOOST_TOFF_CYC,
  parameter int unsigned ZCD_TO_CYC = bpi_pkg::ZCD_TO_CYC,
  parameter int unsigned PH_STEP_CYC = bpi_pkg::PH_STEP_CYC,
  parameter int unsigned IGN_CYC = bpi_pkg::IGN_CYC
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // comparator levels
  input wire bpi_pkg::bpi_sense_t i_sense,
  // digitised resistor settings
  input wire logic [PH_SET_W-1:0] i_preheat_time_set,
  input wire logic [15:0] i_preheat_half_cyc,
  input wire logic [15:0] i_run_half_cyc,
  // gate drives
  output logic o_boost_gate,
  output logic o_inv_low_gate,
  output logic o_inv_high_gate,
  // status
  output logic o_supply_lockout,
  output logic o_fault_latched,
  output logic o_critical_conduction,
  output logic o_bus_open_loop,
  output logic o_bus_under,
  output logic o_bus_over
);
  import bpi_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    bpi_mode_t mode;
    bpi_boost_ph_t bph;
    logic crit;
    logic wait_zcd;
    logic [15:0] bcnt;
    logic [15:0] ton;
    logic [31:0] tmr;
    logic [PH_SET_W-1:0] ph_steps;
    logic [1:0] ign_steps;
    logic lvl1_prev;
    logic zcd_prev;
    logic gate;
    logic fault;
    logic lock;
  } bpi_top_st_t;
  localparam bpi_top_st_t ST_RST = '{mode: M_LOCKOUT, bph: B_OFF, crit: 1'b0,
    wait_zcd: 1'b0, bcnt: 16'h0000, ton: 16'(BOOST_TON_MIN_CYC), tmr: 32'h0000_0000,
    ph_steps: '0, ign_steps: 2'h0, lvl1_prev: 1'b0, zcd_prev: 1'b0, gate: 1'b0,
    fault: 1'b0, lock: 1'b1};

  bpi_top_st_t st_q;
  bpi_top_st_t st_d;
  logic [SENSE_W-1:0] raw_v;
  logic [SENSE_W-1:0] sq_v;
  bpi_sense_t sq;
  logic boost_en;
  logic zcd_fall;
  logic lvl1_rise;
  logic [16:0] ton_next;
  logic inv_run;
  logic [15:0] inv_half;
  logic [15:0] ign_cut;

  // true on the cycle that ends a count of n
  function automatic logic hit(input logic [31:0] c, input logic [31:0] n);
    return (c + 32'h0000_0001) >= n;
  endfunction

  // ---------------------------------------------------------------
  // input qualification
  // ---------------------------------------------------------------
  assign raw_v = i_sense;
  assign sq = sq_v;

  for (genvar gi = 0; gi < SENSE_W; gi++) begin : g_qual
    bpi_qualifier #(
      .QUAL_CYC(QUAL_TAB[gi]),
      .CNT_W(8)
    ) u_qual (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_level(raw_v[gi]),
      .o_level(sq_v[gi])
    );
  end

  // ---------------------------------------------------------------
  // sequencer and boost control
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    zcd_fall = st_q.zcd_prev && !sq.boost_zero_current_in;
    lvl1_rise = sq.inv_low_current_sense_1 && !st_q.lvl1_prev;
    boost_en = (st_q.mode != M_LOCKOUT) && (st_q.mode != M_FAULT) && !sq.bus_voltage_sense_over;
    ton_next = {1'b0, st_q.ton} + 17'(BOOST_TON_STEP_CYC);
    st_d.zcd_prev = sq.boost_zero_current_in;
    st_d.lvl1_prev = sq.inv_low_current_sense_1;
    // mode sequence
    case (st_q.mode)
      M_LOCKOUT: begin
        if (sq.supply_on) begin
          st_d.mode = M_BUS_CHECK;
        end
      end
      M_BUS_CHECK: begin
        if (!sq.bus_voltage_sense_open) begin
          st_d.mode = M_PREHEAT;
          st_d.tmr = 32'h0000_0000;
          st_d.ph_steps = '0;
        end
      end
      M_PREHEAT: begin
        if (st_q.ph_steps >= i_preheat_time_set) begin
          st_d.mode = M_IGNITION;
          st_d.tmr = 32'h0000_0000;
          st_d.ign_steps = 2'h0;
        end else if (hit(st_q.tmr, PH_STEP_CYC)) begin
          st_d.tmr = 32'h0000_0000;
          st_d.ph_steps = st_q.ph_steps + 1'b1;
        end else begin
          st_d.tmr = st_q.tmr + 32'h0000_0001;
        end
      end
      M_IGNITION: begin
        if (lvl1_rise && st_q.ign_steps != IGN_MAX_STEPS) begin
          st_d.ign_steps = st_q.ign_steps + 2'h1;
        end
        if (hit(st_q.tmr, IGN_CYC)) begin
          st_d.mode = M_RUN;
        end else begin
          st_d.tmr = st_q.tmr + 32'h0000_0001;
        end
      end
      M_RUN: begin
        st_d.mode = M_RUN;
      end
      M_FAULT: begin
        if (sq.lamp_removal) begin
          st_d.mode = M_BUS_CHECK;
          st_d.fault = 1'b0;
          st_d.ign_steps = 2'h0;
        end
      end
      default: begin
        st_d.mode = M_LOCKOUT;
      end
    endcase
    // inverter overcurrent latch, any operating mode except lockout
    if (st_q.mode != M_LOCKOUT && sq.inv_low_current_sense_2) begin
      st_d.fault = 1'b1;
      st_d.mode = M_FAULT;
    end
    // boost converter
    if (!boost_en) begin
      st_d.bph = B_OFF;
      st_d.gate = 1'b0;
      st_d.bcnt = 16'h0000;
      st_d.ton = 16'(BOOST_TON_MIN_CYC);
      st_d.crit = 1'b0;
      st_d.wait_zcd = 1'b0;
    end else begin
      case (st_q.bph)
        B_ON: begin
          if (sq.boost_current_sense || hit({16'h0000, st_q.bcnt}, {16'h0000, st_q.ton})) begin
            st_d.bph = B_OFF;
            st_d.gate = 1'b0;
            st_d.bcnt = 16'h0000;
            st_d.wait_zcd = sq.boost_current_sense;
            st_d.ton = (32'(ton_next) > TON_MAX_CYC) ? 16'(TON_MAX_CYC) : ton_next[15:0];
          end else begin
            st_d.bcnt = st_q.bcnt + 16'h0001;
          end
        end
        B_OFF: begin
          if (zcd_fall || hit({16'h0000, st_q.bcnt}, ZCD_TO_CYC)
              || (!st_q.crit && !st_q.wait_zcd && hit({16'h0000, st_q.bcnt}, TOFF_CYC))) begin
            st_d.bph = B_ON;
            st_d.gate = 1'b1;
            st_d.bcnt = 16'h0000;
            st_d.wait_zcd = 1'b0;
            st_d.crit = st_q.crit || zcd_fall;
          end else begin
            st_d.bcnt = st_q.bcnt + 16'h0001;
          end
        end
        default: begin
          st_d.bph = B_OFF;
          st_d.gate = 1'b0;
        end
      endcase
    end
    // supply lockout wins over everything
    if (sq.supply_lockout) begin
      st_d = ST_RST;
    end
    st_d.lock = (st_d.mode == M_LOCKOUT);
  end

  // state register
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // inverter
  // ---------------------------------------------------------------
  // half period per mode; ignition shortens it per step
  always_comb begin
    ign_cut = 16'(32'(st_q.ign_steps) * IGN_HALF_STEP_CYC);
    inv_half = i_run_half_cyc;
    if (st_q.mode == M_PREHEAT) begin
      inv_half = i_preheat_half_cyc;
    end else if (st_q.mode == M_IGNITION) begin
      inv_half = (ign_cut < i_run_half_cyc) ? i_run_half_cyc - ign_cut : 16'h0001;
    end
  end

  assign inv_run = (st_q.mode == M_PREHEAT) || (st_q.mode == M_IGNITION) || (st_q.mode == M_RUN);

  bpi_inv_bridge #(
    .HALF_W(16),
    .DEAD_CYC(DEAD_CYC)
  ) u_bridge (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_run(inv_run),
    .i_half_cyc(inv_half),
    .o_inv_low_gate(o_inv_low_gate),
    .o_inv_high_gate(o_inv_high_gate)
  );

  // outputs from state flops and qualifier flops
  assign o_boost_gate = st_q.gate;
  assign o_supply_lockout = st_q.lock;
  assign o_fault_latched = st_q.fault;
  assign o_critical_conduction = st_q.crit;
  assign o_bus_open_loop = sq.bus_voltage_sense_open;
  assign o_bus_under = sq.bus_voltage_sense_under;
  assign o_bus_over = sq.bus_voltage_sense_over;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_lock_gates;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    st_q.lock [*2] |-> !o_boost_gate && !o_inv_low_gate && !o_inv_high_gate;
  endproperty
  a_lock_gates: assert property (p_lock_gates)
    else $error("gate high during lockout");

  property p_enable;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    st_q.lock && !sq.supply_on |=> st_q.lock;
  endproperty
  a_enable: assert property (p_enable)
    else $error("left lockout without turn-on level");

  property p_supply_lockout_clear;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    sq.supply_lockout |=> st_q.lock && !st_q.fault && st_q.tmr == 32'h0000_0000
      && st_q.ton == 16'(BOOST_TON_MIN_CYC);
  endproperty
  a_supply_lockout_clear: assert property (p_supply_lockout_clear)
    else $error("lockout did not clear state");

  property p_fault;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    !st_q.lock && sq.inv_low_current_sense_2 && !sq.supply_lockout
      |=> st_q.fault ##1 (!o_inv_low_gate && !o_inv_high_gate && !o_boost_gate);
  endproperty
  a_fault: assert property (p_fault)
    else $error("overcurrent did not shut down");

  property p_fault_hold;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    st_q.fault && !sq.lamp_removal && !sq.supply_lockout |=> st_q.fault;
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault released without cause");

  property p_ign_step;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    st_q.mode == M_IGNITION && lvl1_rise && st_q.ign_steps != IGN_MAX_STEPS
      && !sq.inv_low_current_sense_2 && !sq.supply_lockout
      |=> st_q.ign_steps == $past(st_q.ign_steps) + 2'h1;
  endproperty
  a_ign_step: assert property (p_ign_step)
    else $error("ignition step missing");

  property p_ton;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    st_q.gate |-> st_q.bcnt < st_q.ton && 32'(st_q.ton) <= TON_MAX_CYC;
  endproperty
  a_ton: assert property (p_ton)
    else $error("boost on-time beyond limit");

  property p_climit;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    st_q.gate && sq.boost_current_sense && boost_en && !sq.supply_lockout
      |=> !st_q.gate && st_q.wait_zcd;
  endproperty
  a_climit: assert property (p_climit)
    else $error("boost pulse not ended on current limit");

  property p_zcd_start;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    boost_en && !sq.supply_lockout && st_q.bph == B_OFF && zcd_fall |=> st_q.gate && st_q.crit;
  endproperty
  a_zcd_start: assert property (p_zcd_start)
    else $error("zero-current edge did not start pulse");

  property p_timeout;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    st_q.bph == B_OFF |-> 32'(st_q.bcnt) < ZCD_TO_CYC;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("boost off-time passed restart timeout");

  property p_bus_over;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    sq.bus_voltage_sense_over |=> !o_boost_gate;
  endproperty
  a_bus_over: assert property (p_bus_over)
    else $error("boost gate during bus overvoltage");

  property p_preheat;
    @(posedge i_clk_sys) disable iff (!i_rstn)
    st_q.mode == M_PREHEAT && st_q.ph_steps < i_preheat_time_set |=> st_q.mode != M_IGNITION;
  endproperty
  a_preheat: assert property (p_preheat)
    else $error("preheat ended early");

endmodule // bpi_ballast_ctrl
`default_nettype wire

// ---- tb/bpi_choke_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// boost choke with zero-current winding
// ----------------------------------------------------------------
module bpi_choke_model #(
  parameter int unsigned DEMAG_CYC = 10
) (
  // clock
  input wire logic i_clk_sys,
  // gate seen and winding enable
  input wire logic i_boost_gate,
  input wire logic i_zcd_en,
  // zero-current comparator level
  output logic o_zero_current
);
  int demag = 0;
  logic gate_q = 1'b0;
  initial o_zero_current = 1'b0;
  // winding stays positive while the choke demagnetises after turn-off
  always @(posedge i_clk_sys) begin
    #1;
    if (gate_q && !i_boost_gate && i_zcd_en) demag = DEMAG_CYC;
    else if (demag > 0) demag--;
    o_zero_current = (demag > 0); // comparator output, driven low when idle
    gate_q = i_boost_gate;
  end
endmodule // bpi_choke_model
`default_nettype wire

// ---- tb/ballast_pfc_inverter_control_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module ballast_pfc_inverter_control_test;
  import bpi_pkg::*;
  localparam int unsigned TOFF = 40;
  localparam int unsigned ZTO = 80;
  logic i_clk_sys = 1'b0;
  logic i_rstn = 1'b0;
  logic [9:0] sense = 10'h020;
  logic [6:0] ph_set = 7'h00;
  logic [15:0] ph_half = 16'h0020;
  logic [15:0] run_half = 16'h0010;
  logic zcd_en = 1'b0;
  logic zero_current_event;
  logic boost, lo, hi, lockout, fault, crit, b_open, b_under, b_over;
  int num_errors = 0;
  int tests_run = 0;
  int w, o, gap = 0;
  int exp_on[$];
  bit armed = 0;
  logic [31:0] rnd = 32'd724;
  bpi_sense_t sns;
  assign sns = bpi_sense_t'({sense[9:4], zero_current_event, sense[2:0]});
  // ----------------------------------------------------------------
  // clock, design and choke
  // ----------------------------------------------------------------
  always #2.5 i_clk_sys = ~i_clk_sys;
  bpi_ballast_ctrl #(.PH_SET_W(7), .TON_MAX_CYC(1000), .TOFF_CYC(TOFF), .ZCD_TO_CYC(ZTO),
    .PH_STEP_CYC(20), .IGN_CYC(2000)) bpi_ballast_ctrl_inst (.i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn), .i_sense(sns), .i_preheat_time_set(ph_set), .i_preheat_half_cyc(ph_half),
    .i_run_half_cyc(run_half), .o_boost_gate(boost), .o_inv_low_gate(lo), .o_inv_high_gate(hi),
    .o_supply_lockout(lockout), .o_fault_latched(fault), .o_critical_conduction(crit),
    .o_bus_open_loop(b_open), .o_bus_under(b_under), .o_bus_over(b_over));
  bpi_choke_model #(.DEMAG_CYC(10)) bpi_choke_model_inst (.i_clk_sys(i_clk_sys),
    .i_boost_gate(boost), .i_zcd_en(zcd_en), .o_zero_current(zero_current_event));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (exp !== got) begin
      num_errors++;
      $display("ERROR %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // high time of the next boost pulse, then low time to the one after
  task automatic pulse(output int hw);
    int c;
    c = 0;
    while (boost !== 1'b1 && c < 3000) begin step(1); c++; end
    hw = 0;
    while (boost === 1'b1 && hw < 3000) begin step(1); hw++; end
  endtask
  task automatic gap_to_next(output int lw);
    lw = 0;
    while (boost !== 1'b1 && lw < 3000) begin step(1); lw++; end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // inverter gate overlap and dead interval monitor
  // ----------------------------------------------------------------
  always @(negedge i_clk_sys) begin
    if (lo === 1'b1 && hi === 1'b1) check("gate overlap", 0, 1);
    if (lo !== 1'b1 && hi !== 1'b1) gap++;
    else begin
      if (armed && gap != 0) check("dead cycles", DEAD_CYC, gap);
      gap = 0;
      armed = 1;
    end
    if (fault !== 1'b0 || lockout !== 1'b0) armed = 0;
  end
  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial begin
    #300000;
    num_errors++;
    close_out();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rnd = xs(rnd);
    ph_set = {5'h00, rnd[1:0]};
    run_half = 16'h0040 + {12'h000, rnd[7:4]};
    step(6);
    check("lockout flag", 1, lockout);
    check("gates", 0, {boost, lo, hi});
    i_rstn = 1'b1;
    step(3);
    sense[5] = 1'b0;
    sense[4] = 1'b1;
    // startup ramp: 1 us first, +1 us next, fixed off-time
    for (int k = 0; k < 2; k++) exp_on.push_back(BOOST_TON_MIN_CYC + k * BOOST_TON_STEP_CYC);
    pulse(w);
    check("first on cycles", exp_on.pop_front(), w);
    gap_to_next(o);
    check("fixed off cycles", TOFF, o);
    pulse(w);
    check("second on cycles", exp_on.pop_front(), w);
    check("lockout left", 0, lockout);
    $display("test startup done");
    // boost current limit ends pulse, restart by timeout only
    // raise the limit as soon as the next pulse has started
    gap_to_next(o);
    sense[2] = 1'b1;
    w = 0;
    while (boost === 1'b1 && w < 200) begin step(1); w++; end
    sense[2] = 1'b0;
    check("limit cut", 1, w >= 52 && w <= 58);
    gap_to_next(o);
    check("timeout restart", 1, o >= ZTO - 2 && o <= ZTO + 4);
    $display("test current limit done");
    // zero-current fall starts the next pulse early
    zcd_en = 1'b1;
    pulse(w);
    gap_to_next(o);
    check("zcd restart", 1, o >= 11 && o <= 18);
    check("critical mode", 1, crit);
    zcd_en = 1'b0;
    $display("test zero current done");
    // bus comparator flags, one at a time
    for (int i = 0; i < 3; i++) begin
      sense[6+i] = 1'b1;
      step(6);
      check("bus flags", 3'b001 << i, {b_over, b_under, b_open});
      sense[6+i] = 1'b0;
      step(6);
    end
    $display("test bus flags done");
    // second-level inverter overcurrent latches, lamp removal releases
    sense[1] = 1'b1;
    step(90);
    sense[1] = 1'b0;
    step(20);
    check("fault latched", 1, fault);
    check("gates off", 0, {boost, lo, hi});
    sense[9] = 1'b1;
    step(5);
    sense[9] = 1'b0;
    step(5);
    check("fault released", 0, fault);
    $display("test fault done");
    // lockout clears everything, restart ramps from the start
    sense[5] = 1'b1;
    sense[4] = 1'b0;
    step(6);
    check("lockout again", 1, lockout);
    check("gates low", 0, {boost, lo, hi});
    sense[5] = 1'b0;
    sense[4] = 1'b1;
    exp_on.push_back(BOOST_TON_MIN_CYC);
    pulse(w);
    check("ramp restarted", exp_on.pop_front(), w);
    $display("test lockout done");
    // first-level overcurrent in ignition shortens the inverter half period
    sense[0] = 1'b1;
    step(60);
    while (lo === 1'b1) step(1);
    while (lo !== 1'b1) step(1);
    w = 0;
    while (lo === 1'b1 && w < 200) begin step(1); w++; end
    sense[0] = 1'b0;
    check("ignition half", run_half - IGN_HALF_STEP_CYC, w);
    $display("test ignition done");
    close_out();
  end
endmodule // ballast_pfc_inverter_control_test
`default_nettype wire
